// ### inc/ffwg_pkg.sv
// Constants for the fast forcing and write guard block
package ffwg_pkg;
    localparam int          ADDR_W            = 32;
    localparam int          DATA_W            = 32;
    localparam logic [31:0] OFF_SPURIOUS      = 32'hfffff134;
    localparam logic [31:0] OFF_DEBUG_CTRL    = 32'hfffff138;
    localparam logic [31:0] OFF_FORCE_SET     = 32'hfffff140;
    localparam logic [31:0] OFF_FORCE_CLEAR   = 32'hfffff144;
    localparam logic [31:0] OFF_FORCE_STATE   = 32'hfffff148;
    localparam logic [31:0] OFF_GUARD_MODE    = 32'hfffff1e4;
    localparam logic [31:0] OFF_GUARD_STATUS  = 32'hfffff1e8;
    localparam logic [31:0] OFF_IRQ_STATUS    = 32'hfffff1f0;
    localparam logic [31:0] OFF_IRQ_MASK      = 32'hfffff1f4;
    localparam logic [31:0] BLOCK_BASE        = 32'hfffff000;
    localparam logic [23:0] GUARD_KEY_VALUE   = 24'h414943;
    localparam int          GUARD_KEY_LSB     = 8;
    localparam int          GUARD_EN_BIT      = 0;
    localparam int          VIOL_FLAG_BIT     = 0;
    localparam int          VIOL_SRC_LSB      = 8;
    localparam int          VIOL_SRC_W        = 16;
    localparam int          DEBUG_CTRL_W      = 2;
    localparam int          FAST_SRC_BIT      = 0;
    localparam int          IRQ_W             = 2;
    localparam int          IRQ_VIOLATION     = 0;
    localparam int          IRQ_BAD_KEY       = 1;
    localparam logic [31:0] RST_FORCE         = 32'h0000_0000;
    localparam logic [31:0] RST_SPURIOUS      = 32'h0000_0000;
    localparam logic [1:0]  RST_DEBUG_CTRL    = 2'h0;
    localparam logic        RST_GUARD_EN      = 1'b0;
    localparam logic [1:0]  RST_IRQ           = 2'h0;
    localparam logic [31:0] RST_RDATA         = 32'h0000_0000;
endpackage : ffwg_pkg

// ### inc/ffwg_guard_if.sv
// Signals between the register front end and the write guard
`timescale 1ns/1ps
interface ffwg_guard_if;
    import ffwg_pkg::*;
    logic                  wr;
    logic                  rd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
    logic                  guard_en;
    logic                  viol_flag;
    logic [VIOL_SRC_W-1:0] viol_src;
    logic                  blocked;
    logic                  bad_key;
    logic                  viol_event;

    modport front (
        output wr, rd, addr, wdata,
        input  guard_en, viol_flag, viol_src, blocked, bad_key, viol_event
    );
    modport guard (
        input  wr, rd, addr, wdata,
        output guard_en, viol_flag, viol_src, blocked, bad_key, viol_event
    );
endinterface : ffwg_guard_if

// ### rtl/ffwg_guard.sv
// Key-guarded write protection with violation capture
`timescale 1ns/1ps
module ffwg_guard
    import ffwg_pkg::*;
(
    input wire logic   clk_in,
    input wire logic   rst_in,
    ffwg_guard_if.guard gif
);
    logic                  mode_wr;
    logic                  key_ok;
    logic                  status_rd;
    logic                  prot_hit;
    logic [ADDR_W-1:0]     offset;

    assign mode_wr   = gif.wr && (gif.addr == OFF_GUARD_MODE);
    assign key_ok    = gif.wdata[DATA_W-1:GUARD_KEY_LSB] == GUARD_KEY_VALUE;
    assign status_rd = gif.rd && (gif.addr == OFF_GUARD_STATUS);
    assign prot_hit  = gif.wr && gif.guard_en
                       && (gif.addr == OFF_SPURIOUS || gif.addr == OFF_DEBUG_CTRL);
    assign offset    = gif.addr - BLOCK_BASE;

    assign gif.blocked    = prot_hit;
    assign gif.bad_key    = mode_wr && !key_ok;
    assign gif.viol_event = prot_hit;

    // Enable changes only with the correct key
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gif.guard_en <= RST_GUARD_EN;
        end else if (mode_wr && key_ok) begin
            gif.guard_en <= gif.wdata[GUARD_EN_BIT];
        end
    end

    // Violation capture; a new violation wins over the read clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gif.viol_flag <= 1'b0;
            gif.viol_src  <= '0;
        end else if (prot_hit) begin
            gif.viol_flag <= 1'b1;
            gif.viol_src  <= offset[VIOL_SRC_W-1:0];
        end else if (status_rd) begin
            gif.viol_flag <= 1'b0;
        end
    end
endmodule : ffwg_guard

// ### rtl/ffwg_top.sv
// Fast forcing selection, protected configuration and write guard
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

module ffwg_top
    import ffwg_pkg::*;
#(
    parameter int NUM_SRC = 32
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic [ADDR_W-1:0]       addr_in,
    input  wire logic [DATA_W-1:0]       wdata_in,
    input  wire logic                    wr_in,
    input  wire logic                    rd_in,
    output logic      [DATA_W-1:0]       rdata_out,
    output logic      [NUM_SRC-1:0]      forcing_mask_out,
    output logic      [DATA_W-1:0]       spurious_vector_out,
    output logic      [DEBUG_CTRL_W-1:0] debug_control_out,
    output logic                         guard_enabled_out,
    output logic                         irq_out
);

    if (NUM_SRC < 2 || NUM_SRC > DATA_W) begin : g_bad_num_src
        $error("NUM_SRC must lie between 2 and the data width");
    end

    ffwg_guard_if gif ();

    // Address decode
    logic hit_force_set;
    logic hit_force_clear;
    logic hit_force_state;
    logic hit_spurious;
    logic hit_debug;
    logic hit_mode;
    logic hit_status;
    logic hit_irq_status;
    logic hit_irq_mask;

    assign hit_force_set   = addr_in == OFF_FORCE_SET;
    assign hit_force_clear = addr_in == OFF_FORCE_CLEAR;
    assign hit_force_state = addr_in == OFF_FORCE_STATE;
    assign hit_spurious    = addr_in == OFF_SPURIOUS;
    assign hit_debug       = addr_in == OFF_DEBUG_CTRL;
    assign hit_mode        = addr_in == OFF_GUARD_MODE;
    assign hit_status      = addr_in == OFF_GUARD_STATUS;
    assign hit_irq_status  = addr_in == OFF_IRQ_STATUS;
    assign hit_irq_mask    = addr_in == OFF_IRQ_MASK;

    assign gif.wr    = wr_in;
    assign gif.rd    = rd_in;
    assign gif.addr  = addr_in;
    assign gif.wdata = wdata_in;

    ffwg_guard u_guard (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .gif    (gif)
    );

    // Per-source forcing state
    logic [NUM_SRC-1:0] forcing;
    logic               set_wr;
    logic               clear_wr;

    assign set_wr   = wr_in && hit_force_set;
    assign clear_wr = wr_in && hit_force_clear;

    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        if (i == FAST_SRC_BIT) begin : g_fast
            assign forcing[i] = 1'b0;
        end else begin : g_periph
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    forcing[i] <= RST_FORCE[i];
                end else if (set_wr && wdata_in[i]) begin
                    forcing[i] <= 1'b1;
                end else if (clear_wr && wdata_in[i]) begin
                    forcing[i] <= 1'b0;
                end
            end
        end
    end

    // Forcing mask to the fast line router
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            forcing_mask_out <= RST_FORCE[NUM_SRC-1:0];
        end else begin
            forcing_mask_out <= forcing;
        end
    end

    // Protected configuration registers
    logic [DATA_W-1:0]       spurious;
    logic [DEBUG_CTRL_W-1:0] debug_ctrl;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            spurious <= RST_SPURIOUS;
        end else if (wr_in && hit_spurious && !gif.blocked) begin
            spurious <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            debug_ctrl <= RST_DEBUG_CTRL;
        end else if (wr_in && hit_debug && !gif.blocked) begin
            debug_ctrl <= wdata_in[DEBUG_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            spurious_vector_out <= RST_SPURIOUS;
            debug_control_out   <= RST_DEBUG_CTRL;
            guard_enabled_out   <= RST_GUARD_EN;
        end else begin
            spurious_vector_out <= spurious;
            debug_control_out   <= debug_ctrl;
            guard_enabled_out   <= gif.guard_en;
        end
    end

    // Sticky event status, write one to clear, set wins
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] next_irq_mask;

    always_comb begin
        irq_events                = '0;
        irq_events[IRQ_VIOLATION] = gif.viol_event;
        irq_events[IRQ_BAD_KEY]   = gif.bad_key;
    end

    assign irq_clear = (wr_in && hit_irq_status) ? wdata_in[IRQ_W-1:0] : '0;

    // Line follows the mask in the same cycle the mask changes
    assign next_irq_mask = (wr_in && hit_irq_mask) ? wdata_in[IRQ_W-1:0] : irq_mask;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_status <= RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask <= RST_IRQ;
        end else if (wr_in && hit_irq_mask) begin
            irq_mask <= wdata_in[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(((irq_status & ~irq_clear) | irq_events) & next_irq_mask);
        end
    end

    // Read multiplexer; write-only and unmapped offsets read zero
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (hit_force_state) begin
            next_rdata[NUM_SRC-1:0] = forcing;
        end else if (hit_spurious) begin
            next_rdata = spurious;
        end else if (hit_debug) begin
            next_rdata[DEBUG_CTRL_W-1:0] = debug_ctrl;
        end else if (hit_mode) begin
            next_rdata[GUARD_EN_BIT] = gif.guard_en;
        end else if (hit_status) begin
            next_rdata[VIOL_FLAG_BIT] = gif.viol_flag;
            next_rdata[VIOL_SRC_LSB +: VIOL_SRC_W] = gif.viol_src;
        end else if (hit_irq_status) begin
            next_rdata[IRQ_W-1:0] = irq_status;
        end else if (hit_irq_mask) begin
            next_rdata[IRQ_W-1:0] = irq_mask;
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= RST_RDATA;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= RST_RDATA;
        end
    end

endmodule : ffwg_top

// ### testbench/ffwg_top_sva.sv
// Port assertions for the fast forcing and write guard block
`timescale 1ns/1ps
module ffwg_top_sva
    import ffwg_pkg::*;
#(
    parameter int NUM_SRC = 32
) (
    input wire logic                    clk_in,
    input wire logic                    rst_in,
    input wire logic [ADDR_W-1:0]       addr_in,
    input wire logic [DATA_W-1:0]       wdata_in,
    input wire logic                    wr_in,
    input wire logic                    rd_in,
    input wire logic [DATA_W-1:0]       rdata_out,
    input wire logic [NUM_SRC-1:0]      forcing_mask_out,
    input wire logic [DATA_W-1:0]       spurious_vector_out,
    input wire logic [DEBUG_CTRL_W-1:0] debug_control_out,
    input wire logic                    guard_enabled_out,
    input wire logic                    irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_wr(logic [31:0] a); wr_in && addr_in == a; endsequence
    sequence s_key_ok; s_wr(OFF_GUARD_MODE) ##0 (wdata_in[31:8] == GUARD_KEY_VALUE); endsequence
    sequence s_key_bad; s_wr(OFF_GUARD_MODE) ##0 (wdata_in[31:8] != GUARD_KEY_VALUE); endsequence
    a_force_set: assert property (s_wr(OFF_FORCE_SET) |-> ##2 ((forcing_mask_out[NUM_SRC-1:1]
        & $past(wdata_in[NUM_SRC-1:1], 2)) == $past(wdata_in[NUM_SRC-1:1], 2))) else $error("set lost");
    a_force_clear: assert property (s_wr(OFF_FORCE_CLEAR) |-> ##2 ((forcing_mask_out[NUM_SRC-1:1]
        & $past(wdata_in[NUM_SRC-1:1], 2)) == '0)) else $error("clear lost");
    a_state_read: assert property ($past(rd_in) && $past(addr_in) == OFF_FORCE_STATE
        |-> rdata_out[NUM_SRC-1:0] == forcing_mask_out) else $error("state read wrong");
    a_key_good: assert property (s_key_ok |-> ##2 guard_enabled_out == $past(wdata_in[0], 2))
        else $error("guard update lost");
    a_key_bad: assert property (s_key_bad |-> ##2 $stable(guard_enabled_out)) else $error("bad key taken");
    a_guard_block: assert property ((guard_enabled_out && !$past(wr_in && addr_in == OFF_GUARD_MODE))
        ##0 (s_wr(OFF_SPURIOUS) or s_wr(OFF_DEBUG_CTRL)) |-> ##2 ($stable(spurious_vector_out)
        && $stable(debug_control_out))) else $error("guarded write taken");
    a_open_write: assert property ((!guard_enabled_out && !$past(wr_in && addr_in == OFF_GUARD_MODE))
        ##0 s_wr(OFF_SPURIOUS) |-> ##2 spurious_vector_out == $past(wdata_in, 2)) else $error("open write lost");
    a_bit0_zero: assert property (forcing_mask_out[FAST_SRC_BIT] == 1'b0) else $error("bit0 set");
    a_key_reads0: assert property ($past(rd_in) && $past(addr_in) == OFF_GUARD_MODE
        |-> rdata_out[31:8] == '0) else $error("key visible");
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == '0) else $error("rdata not idle");
endmodule // ffwg_top_sva

bind ffwg_top ffwg_top_sva #(.NUM_SRC(NUM_SRC)) u_ffwg_top_sva (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .forcing_mask_out(forcing_mask_out), .spurious_vector_out(spurious_vector_out),
    .debug_control_out(debug_control_out), .guard_enabled_out(guard_enabled_out), .irq_out(irq_out));

// ### testbench/ffwg_top_tb.sv
// Self-checking bench for the fast forcing and write guard block
`timescale 1ns/1ps
module ffwg_top_tb;
    import ffwg_pkg::*;
    localparam logic [23:0] BAD = 24'h414942;
    logic        clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, rd_q = 0;
    logic [31:0] addr_in = '0, wdata_in = '0, rdata_out, forcing_mask_out, spurious_vector_out, m, d;
    logic [1:0]  debug_control_out;
    logic        guard_enabled_out, irq_out;
    logic [31:0] exp_q[$];
    logic [31:0] regs[8] = '{OFF_FORCE_STATE, OFF_GUARD_MODE, OFF_GUARD_STATUS, OFF_SPURIOUS,
                             OFF_DEBUG_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK, 32'hfffff200};
    int          err_count = 0, checked = 0;
    always #2.5 clk_in = ~clk_in;
    ffwg_top #(.NUM_SRC(32)) u_ffwg_top (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .forcing_mask_out(forcing_mask_out), .spurious_vector_out(spurious_vector_out),
        .debug_control_out(debug_control_out), .guard_enabled_out(guard_enabled_out), .irq_out(irq_out));
    task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1; rd_in <= 1'b0; addr_in <= a; wdata_in <= v;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] x);
        @(posedge clk_in);
        rd_in <= 1'b1; wr_in <= 1'b0; addr_in <= a;
        exp_q.push_back(x);
    endtask
    task idle;
        @(posedge clk_in);
        wr_in <= 1'b0; rd_in <= 1'b0;
    endtask
    task settle;
        idle();
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Read results are judged against the oldest note
    always @(posedge clk_in) rd_q <= rd_in;
    always @(negedge clk_in) if (rd_q === 1'b1) begin
        if (exp_q.size() == 0) cmp("read queue", 32'h1, 32'h0);
        else cmp("read data", exp_q.pop_front(), rdata_out);
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(64807));
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        foreach (regs[i]) rd(regs[i], 32'h0);
        wr(OFF_FORCE_SET, 32'hffff_ffff);
        m = 32'hffff_fffe;
        repeat (8) begin
            d = $urandom;
            wr(OFF_FORCE_SET, d);
            m |= d & 32'hffff_fffe;
            d = $urandom;
            wr(OFF_FORCE_CLEAR, d);
            m &= ~d;
            rd(OFF_FORCE_STATE, m);
        end
        wr(OFF_FORCE_STATE, 32'h0);
        rd(OFF_FORCE_STATE, m);
        settle();
        cmp("forcing mask", m, forcing_mask_out);
        wr(OFF_SPURIOUS, 32'h1234_5678);
        wr(OFF_DEBUG_CTRL, 32'h3);
        wr(OFF_IRQ_MASK, 32'h3);
        wr(OFF_GUARD_MODE, {BAD, 8'h01});
        rd(OFF_GUARD_MODE, 32'h0);
        settle();
        cmp("irq bad key", 32'h1, irq_out);
        rd(OFF_IRQ_STATUS, 32'h2);
        wr(OFF_IRQ_STATUS, 32'h2);
        settle();
        cmp("irq cleared", 32'h0, irq_out);
        wr(OFF_GUARD_MODE, {GUARD_KEY_VALUE, 8'h01});
        rd(OFF_GUARD_MODE, 32'h1);
        wr(OFF_SPURIOUS, 32'h0000_dead);
        rd(OFF_SPURIOUS, 32'h1234_5678);
        rd(OFF_GUARD_STATUS, 32'h0001_3401);
        rd(OFF_GUARD_STATUS, 32'h0001_3400);
        wr(OFF_DEBUG_CTRL, 32'h0);
        rd(OFF_GUARD_STATUS, 32'h0001_3801);
        rd(OFF_DEBUG_CTRL, 32'h3);
        rd(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        settle();
        cmp("irq masked", 32'h0, irq_out);
        cmp("guard on", 32'h1, guard_enabled_out);
        cmp("debug out", 32'h3, debug_control_out);
        wr(OFF_GUARD_MODE, {BAD, 8'h00});
        rd(OFF_GUARD_MODE, 32'h1);
        wr(OFF_GUARD_MODE, {GUARD_KEY_VALUE, 8'h00});
        rd(OFF_GUARD_MODE, 32'h0);
        wr(OFF_SPURIOUS, 32'h0000_beef);
        rd(OFF_SPURIOUS, 32'h0000_beef);
        rd(OFF_IRQ_STATUS, 32'h3);
        settle();
        cmp("guard off", 32'h0, guard_enabled_out);
        cmp("spurious out", 32'h0000_beef, spurious_vector_out);
        cmp("read queue empty", 32'h0, exp_q.size());
        finish_test();
    end
endmodule // ffwg_top_tb
